// ==== hw/compare_match_timer.sv ====
// Four-channel compare match timer with its register port.
// Assumes a single-cycle strobe master on mclk and synchronous ticks.
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// R01 - Four channels, each an 8-bit prescaler driving a 24-bit up counter.
// R02 - Period is source period times prescale plus one times compare.
// R03 - Counter value of each channel is readable at any time.
// R04 - A flagged, enabled channel interrupt raises the wake request.
// R05 - Each channel holds a 24-bit compare value and its own request.
// R06 - Each channel picks its counting clock from six sources.
// R07 - Mode field: 0 one-shot, 1 periodic, 2 toggle, 3 continuous.
// R08 - Setting count enable starts counting up from the initial value.
// R09 - Counter reaching compare sets the timeout flag.
// R10 - Interrupt only while timeout flag and interrupt enable are set.
// R11 - One-shot match stops, reloads the counter and clears enable.
// R12 - Periodic match reloads the counter and keeps counting.
// R13 - Periodic runs until disabled; each match sets the flag again.
// R14 - Toggle match sets the flag and flips the toggle pin.
// R15 - Toggle reloads and keeps counting, giving a square wave.
// R16 - Continuous mode: match sets flag, counter runs on and wraps.
// R17 - Software clears the flag by writing one; zero leaves it.
// R18 - The reload and restart value of the counter is zero.
module compare_match_timer (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] reg_address,
  input wire logic [31:0] reg_write_data,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_read_data,
  input wire logic [4:0] source_tick,
  output logic [3:0] toggle_output_pin,
  output logic [3:0] channel_irq,
  output logic irq,
  output logic wake_request
);

  localparam int NCH = timer_pkg::CHANNELS;
  localparam int CW = timer_pkg::COUNT_WIDTH;
  localparam int PW = timer_pkg::PRESCALE_WIDTH;

  // ************************************************************
  // State
  // ************************************************************
  logic [NCH-1:0] count_enable;
  logic [NCH-1:0] next_count_enable;
  logic [NCH-1:0] irq_enable;
  logic [NCH-1:0] next_irq_enable;
  logic [NCH-1:0][1:0] mode_field;
  logic [NCH-1:0][1:0] next_mode_field;
  logic [NCH-1:0][2:0] source_select;
  logic [NCH-1:0][2:0] next_source_select;
  logic [NCH-1:0][PW-1:0] prescale;
  logic [NCH-1:0][PW-1:0] next_prescale;
  logic [NCH-1:0][CW-1:0] compare_value;
  logic [NCH-1:0][CW-1:0] next_compare_value;
  logic [NCH-1:0][CW-1:0] counter_value;
  logic [NCH-1:0][CW-1:0] next_counter_value;
  logic [NCH-1:0] toggle_state;
  logic [NCH-1:0] next_toggle_state;
  logic [31:0] next_read_data;
  logic [NCH-1:0] tick;
  logic [NCH-1:0] match;
  logic [NCH-1:0] restart;
  logic [NCH-1:0] flag_clear;
  logic [NCH-1:0] timeout_flag;
  logic [NCH-1:0] irq_mask;
  logic mask_write;

  // True when addr hits register ofs of channel ch
  function automatic logic is_chan_reg(input logic [7:0] addr,
    input logic [1:0] ch, input logic [7:0] ofs);
    return (addr[7:6] == 2'h0) && (addr[5:4] == ch) &&
      (addr[3:0] == ofs[3:0]);
  endfunction : is_chan_reg

  // ************************************************************
  // Per-channel clock selection and prescale
  // ************************************************************
  // One divider per channel keeps the channels independent
  for (genvar g = 0; g < NCH; g++)
  begin : gen_tick
    tick_source #(
      .PRESCALE_WIDTH(PW),
      .SOURCE_TICKS(timer_pkg::SOURCE_TICKS)
    ) u_tick (
      .mclk(mclk),
      .reset(reset),
      .source_select(source_select[g]),
      .source_tick(source_tick),
      .prescale(prescale[g]),
      .restart(restart[g]),
      .run(count_enable[g]),
      .tick(tick[g])
    ); // R01
  end

  // ************************************************************
  // Counting, compare match and register writes
  // ************************************************************
  // Counting first, then software writes override control fields
  always_comb
  begin
    logic [CW-1:0] inc;
    inc = '0;
    next_count_enable = count_enable;
    next_irq_enable = irq_enable;
    next_mode_field = mode_field;
    next_source_select = source_select;
    next_prescale = prescale;
    next_compare_value = compare_value;
    next_counter_value = counter_value;
    next_toggle_state = toggle_state;
    match = '0;
    restart = '0;
    flag_clear = '0;
    for (int i = 0; i < NCH; i++)
    begin
      if (count_enable[i] && tick[i])
      begin
        inc = counter_value[i] + CW'(1); // R01
        if (inc == compare_value[i])
        begin
          match[i] = 1'b1; // R09
          unique case (mode_field[i]) // R07
            timer_pkg::MODE_ONE_SHOT:
            begin
              next_counter_value[i] = timer_pkg::COUNT_INITIAL; // R11 R18
              next_count_enable[i] = 1'b0; // R11
            end
            timer_pkg::MODE_PERIODIC:
            begin
              next_counter_value[i] = timer_pkg::COUNT_INITIAL; // R12 R13
            end
            timer_pkg::MODE_TOGGLE:
            begin
              next_counter_value[i] = timer_pkg::COUNT_INITIAL; // R15
              next_toggle_state[i] = ~toggle_state[i]; // R14 R15
            end
            timer_pkg::MODE_CONTINUOUS:
            begin
              next_counter_value[i] = inc; // R16
            end
          endcase
        end
        else
        begin
          // Plain increment wraps at the top of the counter
          next_counter_value[i] = inc; // R16
        end
      end
      if (reg_write && is_chan_reg(reg_address, 2'(i),
        timer_pkg::OFS_CONTROL))
      begin
        next_count_enable[i] =
          reg_write_data[timer_pkg::POS_COUNT_ENABLE];
        next_irq_enable[i] = reg_write_data[timer_pkg::POS_IRQ_ENABLE];
        next_mode_field[i] = reg_write_data[timer_pkg::POS_MODE +: 2];
        next_source_select[i] =
          reg_write_data[timer_pkg::POS_SOURCE +: 3];
        next_prescale[i] = reg_write_data[timer_pkg::POS_PRESCALE +: PW];
        // Only a fresh enable restarts; rewriting a running one keeps it
        if (reg_write_data[timer_pkg::POS_COUNT_ENABLE] &&
          !count_enable[i])
        begin
          restart[i] = 1'b1; // R08
          next_counter_value[i] = timer_pkg::COUNT_INITIAL; // R08 R18
        end
      end
      if (reg_write && is_chan_reg(reg_address, 2'(i),
        timer_pkg::OFS_COMPARE))
      begin
        // Takes effect at once, also while running
        next_compare_value[i] = reg_write_data[CW-1:0]; // R05 R16
      end
      // Write-one-to-clear from the channel word or the global word
      flag_clear[i] =
        (reg_write && is_chan_reg(reg_address, 2'(i),
          timer_pkg::OFS_IRQ_STATUS) &&
          reg_write_data[timer_pkg::POS_TIMEOUT_FLAG]) ||
        (reg_write && (reg_address == timer_pkg::OFS_GLOBAL_STATUS) &&
          reg_write_data[i]); // R17
    end
  end

  // Registers the channel state
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      count_enable <= '0;
      irq_enable <= '0;
      mode_field <= {NCH{timer_pkg::RST_MODE}};
      source_select <= {NCH{timer_pkg::RST_SOURCE}};
      prescale <= {NCH{timer_pkg::RST_PRESCALE}};
      compare_value <= {NCH{timer_pkg::RST_COMPARE}};
      counter_value <= {NCH{timer_pkg::COUNT_INITIAL}};
      toggle_state <= '0;
    end
    else
    begin
      count_enable <= next_count_enable;
      irq_enable <= next_irq_enable;
      mode_field <= next_mode_field;
      source_select <= next_source_select;
      prescale <= next_prescale;
      compare_value <= next_compare_value;
      counter_value <= next_counter_value;
      toggle_state <= next_toggle_state;
    end
  end

  // Pin level holds when the channel leaves toggle mode
  assign toggle_output_pin = toggle_state; // R14

  // ************************************************************
  // Flags and interrupts
  // ************************************************************
  assign mask_write =
    reg_write && (reg_address == timer_pkg::OFS_GLOBAL_MASK);

  timeout_irq #(
    .CHANNELS(NCH)
  ) u_irq (
    .mclk(mclk),
    .reset(reset),
    .event_set(match),
    .flag_clear(flag_clear),
    .mask_write(mask_write),
    .mask_data(reg_write_data[NCH-1:0]),
    .irq_enable(irq_enable),
    .timeout_flag(timeout_flag),
    .irq_mask(irq_mask),
    .channel_irq(channel_irq),
    .irq(irq),
    .wake_request(wake_request)
  );

  // ************************************************************
  // Read port
  // ************************************************************
  // Unmapped addresses read zero; data stand one cycle only
  always_comb
  begin
    logic [1:0] ch;
    ch = reg_address[5:4];
    next_read_data = '0;
    if (reg_read && (reg_address[7:6] == 2'h0))
    begin
      unique case (reg_address[3:0])
        timer_pkg::OFS_CONTROL[3:0]:
        begin
          next_read_data[timer_pkg::POS_COUNT_ENABLE] = count_enable[ch];
          next_read_data[timer_pkg::POS_IRQ_ENABLE] = irq_enable[ch];
          next_read_data[timer_pkg::POS_MODE +: 2] = mode_field[ch];
          next_read_data[timer_pkg::POS_SOURCE +: 3] = source_select[ch];
          next_read_data[timer_pkg::POS_PRESCALE +: PW] = prescale[ch];
        end
        timer_pkg::OFS_COMPARE[3:0]:
        begin
          next_read_data[CW-1:0] = compare_value[ch];
        end
        timer_pkg::OFS_COUNTER[3:0]:
        begin
          next_read_data[CW-1:0] = counter_value[ch]; // R03
        end
        timer_pkg::OFS_IRQ_STATUS[3:0]:
        begin
          next_read_data[timer_pkg::POS_TIMEOUT_FLAG] = timeout_flag[ch];
        end
        default:
        begin
          next_read_data = '0;
        end
      endcase
    end
    else if (reg_read && (reg_address == timer_pkg::OFS_GLOBAL_STATUS))
    begin
      next_read_data[NCH-1:0] = timeout_flag;
    end
    else if (reg_read && (reg_address == timer_pkg::OFS_GLOBAL_MASK))
    begin
      next_read_data[NCH-1:0] = irq_mask;
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      reg_read_data <= '0;
    end
    else
    begin
      reg_read_data <= next_read_data;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  for (genvar g = 0; g < NCH; g++)
  begin : gen_check
    AST_ONE_SHOT_STOP: assert property ( // R11
      match[g] && (mode_field[g] == timer_pkg::MODE_ONE_SHOT) &&
      !reg_write |=> !count_enable[g] && (counter_value[g] == '0))
      else $error("one-shot match did not stop the channel");
    AST_PERIODIC_RELOAD: assert property ( // R12
      match[g] && (mode_field[g] == timer_pkg::MODE_PERIODIC) &&
      !reg_write |=> count_enable[g] && (counter_value[g] == '0))
      else $error("periodic match did not reload and continue");
    AST_TOGGLE_FLIP: assert property ( // R14
      match[g] && (mode_field[g] == timer_pkg::MODE_TOGGLE)
      |=> toggle_output_pin[g] != $past(toggle_output_pin[g]))
      else $error("toggle match did not flip the pin");
    AST_TOGGLE_HOLD: assert property ( // R15
      !(match[g] && (mode_field[g] == timer_pkg::MODE_TOGGLE))
      |=> $stable(toggle_output_pin[g]))
      else $error("toggle pin moved without a match");
    AST_CONTINUOUS_RUN: assert property ( // R16
      match[g] && (mode_field[g] == timer_pkg::MODE_CONTINUOUS) &&
      !reg_write |=> counter_value[g] == $past(compare_value[g]))
      else $error("continuous match reloaded the counter");
    AST_FLAG_SET: assert property ( // R09
      match[g] |=> timeout_flag[g])
      else $error("match did not set the timeout flag");
    AST_IRQ_GATE: assert property ( // R10
      channel_irq[g] == (timeout_flag[g] && irq_enable[g]))
      else $error("channel request not gated by enable");
    AST_COUNTER_READ: assert property ( // R03
      reg_read && is_chan_reg(reg_address, 2'(g),
        timer_pkg::OFS_COUNTER)
      |=> reg_read_data[CW-1:0] == $past(counter_value[g]))
      else $error("counter read returned a stale value");
    AST_START_ZERO: assert property ( // R08
      reg_write && !count_enable[g] &&
      is_chan_reg(reg_address, 2'(g), timer_pkg::OFS_CONTROL) &&
      reg_write_data[timer_pkg::POS_COUNT_ENABLE]
      |=> count_enable[g] && (counter_value[g] == '0))
      else $error("enable did not start from the initial value");
  end

  AST_WAKE: assert property ( // R04
    wake_request == |(timeout_flag & irq_enable))
    else $error("wake request disagrees with enabled flags");

  COV_ONE_SHOT: cover property (
    match[0] && (mode_field[0] == timer_pkg::MODE_ONE_SHOT));
  COV_PERIODIC_AGAIN: cover property (
    match[0] && (mode_field[0] == timer_pkg::MODE_PERIODIC)
    ##[1:300] match[0]);
  COV_TOGGLE: cover property (
    match[1] && (mode_field[1] == timer_pkg::MODE_TOGGLE));
  COV_IRQ: cover property (irq);

endmodule : compare_match_timer

`default_nettype wire

// ==== hw/timer_pkg.sv ====
// Constants, field layout and mode codes of the four-channel timer.
// Assumes every user writes package::name and imports nothing.
package timer_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int CHANNELS = 4;
  localparam int COUNT_WIDTH = 24;
  localparam int PRESCALE_WIDTH = 8;
  localparam int SOURCE_COUNT = 6;
  localparam int SOURCE_TICKS = 5;
  localparam int SELECT_WIDTH = 3;
  localparam int ADDR_WIDTH = 8;
  localparam int DATA_WIDTH = 32;

  // ************************************************************
  // Register offsets: channel n sits at n * 0x10 plus the first four; the last two are global addresses
  // ************************************************************
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_COMPARE = 8'h04;
  localparam logic [7:0] OFS_COUNTER = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFS_GLOBAL_STATUS = 8'h40;
  localparam logic [7:0] OFS_GLOBAL_MASK = 8'h44;

  // ************************************************************
  // Field positions of the control/status word
  // ************************************************************
  localparam int POS_COUNT_ENABLE = 30;
  localparam int POS_IRQ_ENABLE = 29;
  localparam int POS_MODE = 27;
  localparam int POS_SOURCE = 24;
  localparam int POS_PRESCALE = 0;
  localparam int POS_TIMEOUT_FLAG = 0;

  // ************************************************************
  // Reset and initial values
  // ************************************************************
  localparam logic [23:0] COUNT_INITIAL = 24'h000000;
  localparam logic [23:0] RST_COMPARE = 24'h000000;
  localparam logic [7:0] RST_PRESCALE = 8'h00;
  localparam logic [2:0] RST_SOURCE = 3'h0;
  localparam logic [1:0] RST_MODE = 2'h0;
  localparam logic [3:0] RST_MASK = 4'h0;

  // ************************************************************
  // Operating modes
  // ************************************************************
  typedef enum logic [1:0] {
    MODE_ONE_SHOT = 2'h0,
    MODE_PERIODIC = 2'h1,
    MODE_TOGGLE = 2'h2,
    MODE_CONTINUOUS = 2'h3
  } mode_type;

endpackage : timer_pkg

// ==== hw/tick_source.sv ====
// Clock source select and prescaler of one timer channel.
// Assumes source ticks are one-cycle enables synchronous to mclk.
`timescale 1ns/10ps
`default_nettype none

module tick_source #(
  parameter int PRESCALE_WIDTH = 8,
  parameter int SOURCE_TICKS = 5
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [2:0] source_select,
  input wire logic [SOURCE_TICKS-1:0] source_tick,
  input wire logic [PRESCALE_WIDTH-1:0] prescale,
  input wire logic restart,
  input wire logic run,
  output logic tick
);

  logic [PRESCALE_WIDTH-1:0] prescale_count;
  logic [PRESCALE_WIDTH-1:0] next_prescale_count;
  logic source_pulse;

  // ************************************************************
  // Source select and prescale division
  // ************************************************************
  // Code 0 is mclk itself, codes 1..5 the tick inputs, others idle
  always_comb
  begin
    source_pulse = 1'b0;
    if (source_select == 3'h0)
    begin
      source_pulse = 1'b1; // R06
    end
    else if (source_select <= 3'(SOURCE_TICKS))
    begin
      source_pulse = source_tick[source_select - 3'h1]; // R06
    end
    tick = run && !restart && source_pulse &&
      (prescale_count == prescale); // R02
    next_prescale_count = prescale_count;
    if (restart || !run)
    begin
      next_prescale_count = '0;
    end
    else if (source_pulse)
    begin
      // One tick per prescale+1 source pulses
      next_prescale_count = tick ? '0 :
        prescale_count + PRESCALE_WIDTH'(1); // R02
    end
  end

  // Stopped channels keep the divider cleared for a fresh start
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      prescale_count <= '0;
    end
    else
    begin
      prescale_count <= next_prescale_count;
    end
  end

endmodule : tick_source

`default_nettype wire

// ==== hw/timeout_irq.sv ====
// Sticky timeout flags, interrupt mask and the interrupt outputs.
// Assumes set and clear vectors arrive as one-cycle pulses.
`timescale 1ns/10ps
`default_nettype none

module timeout_irq #(
  parameter int CHANNELS = 4
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [CHANNELS-1:0] event_set,
  input wire logic [CHANNELS-1:0] flag_clear,
  input wire logic mask_write,
  input wire logic [CHANNELS-1:0] mask_data,
  input wire logic [CHANNELS-1:0] irq_enable,
  output logic [CHANNELS-1:0] timeout_flag,
  output logic [CHANNELS-1:0] irq_mask,
  output logic [CHANNELS-1:0] channel_irq,
  output logic irq,
  output logic wake_request
);

  logic [CHANNELS-1:0] next_timeout_flag;
  logic [CHANNELS-1:0] next_irq_mask;

  // ************************************************************
  // Flags and mask
  // ************************************************************
  // Set beats clear so a match in the clearing cycle is kept
  always_comb
  begin
    next_timeout_flag = event_set | (timeout_flag & ~flag_clear); // R09
    next_irq_mask = mask_write ? mask_data : irq_mask;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      timeout_flag <= '0;
      irq_mask <= CHANNELS'(timer_pkg::RST_MASK);
    end
    else
    begin
      timeout_flag <= next_timeout_flag;
      irq_mask <= next_irq_mask;
    end
  end

  // Per-channel requests ignore the mask; the shared line honours it
  assign channel_irq = timeout_flag & irq_enable; // R05 R10
  assign irq = |(timeout_flag & irq_enable & irq_mask); // R10
  assign wake_request = |(timeout_flag & irq_enable); // R04

endmodule : timeout_irq

`default_nettype wire

// ==== bench/compare_match_timer_bench.sv ====
// Self-checking bench for the four-channel compare match timer.
// Assumes reads answer one cycle after the strobe and writes act at once.
`timescale 1ns/10ps
`default_nettype none

module compare_match_timer_bench;
  // ************************************************************
  // Signals
  // ************************************************************
  logic mclk;
  logic reset;
  logic [7:0] reg_address;
  logic [31:0] reg_write_data;
  logic reg_write;
  logic reg_read;
  logic [31:0] reg_read_data;
  logic [4:0] source_tick;
  logic [3:0] toggle_output_pin;
  logic [3:0] channel_irq;
  logic irq;
  logic wake_request;
  logic [1:0] tick_phase;
  logic [31:0] rdata;
  logic [31:0] first_count;
  int err_total;
  int checks;
  int n;

  compare_match_timer DUT (
    .mclk(mclk),
    .reset(reset),
    .reg_address(reg_address),
    .reg_write_data(reg_write_data),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_read_data(reg_read_data),
    .source_tick(source_tick),
    .toggle_output_pin(toggle_output_pin),
    .channel_irq(channel_irq),
    .irq(irq),
    .wake_request(wake_request)
  );

  // ************************************************************
  // Clock and source ticks
  // ************************************************************
  // Clock of 10 ns
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  // All five sources pulse once every fourth cycle
  initial tick_phase = 2'h0;
  initial source_tick = 5'h00;
  always @(posedge mclk)
  begin
    tick_phase <= tick_phase + 2'h1;
    source_tick <= {5{tick_phase == 2'h3}};
  end

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic check(input string what, input logic [31:0] expv,
                       input logic [31:0] got);
    checks++;
    if (got !== expv)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, expv, got);
    end
  endtask : check

  // Single-cycle write; returns just after the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_address <= a;
    reg_write_data <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
    #1;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_address <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1;
    rdata = reg_read_data;
  endtask : rd

  // Counts edges until the channel request rises, bounded
  task automatic wait_flag(input int ch, output int cnt);
    cnt = 0;
    while (cnt < 200 && channel_irq[ch] !== 1'b1)
    begin
      @(posedge mclk);
      #1;
      cnt++;
    end
  endtask : wait_flag

  function automatic logic [31:0] ctl(input logic en, input logic ie,
    input logic [1:0] mode, input logic [2:0] src, input logic [7:0] ps);
    ctl = {1'b0, en, ie, mode, src, 16'h0000, ps};
  endfunction : ctl

  task automatic stop_test;
    if (err_total == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  // ************************************************************
  // Watchdog: the tests need well under a thousand cycles
  // ************************************************************
  initial
  begin
    #200000;
    err_total++;
    stop_test();
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial
  begin
    reset = 1'b1;
    reg_address = 8'h00;
    reg_write_data = 32'h0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    err_total = 0;
    checks = 0;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    // Reset values and an unmapped place
    rd(8'h00); check("control reset", 32'h0, rdata);
    rd(8'h04); check("compare reset", 32'h0, rdata);
    rd(8'h44); check("mask reset", 32'h0, rdata);
    rd(8'h50); check("unmapped read", 32'h0, rdata);
    // One-shot on channel 0: compare 5, prescale 1
    wr(8'h04, 32'h05);
    rd(8'h04); check("compare0", 32'h05, rdata);
    wr(8'h00, ctl(1'b1, 1'b1, 2'h0, 3'h0, 8'h01));
    wait_flag(0, n);
    check("one-shot period", 32'h0A, n);
    check("wake", 32'h1, wake_request);
    check("irq masked", 32'h0, irq);
    check("pin0 idle", 32'h0, toggle_output_pin[0]);
    rd(8'h00); check("one-shot enable", ctl(1'b0, 1'b1, 2'h0, 3'h0, 8'h01), rdata);
    rd(8'h08); check("one-shot counter", 32'h0, rdata);
    rd(8'h0C); check("flag0 set", 32'h1, rdata);
    rd(8'h40); check("global flags", 32'h1, rdata);
    wr(8'h0C, 32'h0);
    rd(8'h0C); check("flag0 write zero", 32'h1, rdata);
    wr(8'h44, 32'h1);
    check("irq unmasked", 32'h1, irq);
    wr(8'h0C, 32'h1);
    check("flag0 cleared", 32'h0, channel_irq[0]);
    check("irq after clear", 32'h0, irq);
    check("wake after clear", 32'h0, wake_request);
    // Periodic on channel 1: compare 20
    wr(8'h14, 32'h14);
    wr(8'h10, ctl(1'b1, 1'b1, 2'h1, 3'h0, 8'h00));
    wait_flag(1, n);
    check("periodic first", 32'h14, n);
    rd(8'h10); check("periodic enable", ctl(1'b1, 1'b1, 2'h1, 3'h0, 8'h00), rdata);
    wr(8'h1C, 32'h1);
    wait_flag(1, n);
    check("periodic second", 32'h10, n);
    rd(8'h18); check("periodic reload", 32'h1, rdata[23:0] < 24'h3);
    // Dropping the enable bit hides the request, flag stays
    wr(8'h10, ctl(1'b1, 1'b0, 2'h1, 3'h0, 8'h00));
    check("irq disabled", 32'h0, channel_irq[1]);
    rd(8'h1C); check("flag1 kept", 32'h1, rdata);
    wr(8'h10, ctl(1'b0, 1'b0, 2'h1, 3'h0, 8'h00));
    rd(8'h18);
    first_count = rdata;
    repeat (10) @(posedge mclk);
    rd(8'h18); check("stopped counter", first_count, rdata);
    // Toggle on channel 2: compare 3
    wr(8'h24, 32'h03);
    wr(8'h20, ctl(1'b1, 1'b1, 2'h2, 3'h0, 8'h00));
    wait_flag(2, n);
    check("toggle period", 32'h03, n);
    check("pin2 high", 32'h1, toggle_output_pin[2]);
    wr(8'h2C, 32'h1);
    wait_flag(2, n);
    check("toggle again", 32'h01, n);
    check("pin2 low", 32'h0, toggle_output_pin[2]);
    wr(8'h20, ctl(1'b0, 1'b0, 2'h2, 3'h0, 8'h00));
    // Continuous on channel 3: compare 4, counter runs past it
    wr(8'h34, 32'h04);
    wr(8'h30, ctl(1'b1, 1'b1, 2'h3, 3'h0, 8'h00));
    wait_flag(3, n);
    check("continuous period", 32'h04, n);
    rd(8'h38);
    check("continuous runs on", 32'h1, rdata[23:0] > 24'h4);
    first_count = rdata;
    rd(8'h38);
    check("counter live", 32'h1, rdata > first_count);
    // Channel 0 on source 3, ticks every fourth cycle, compare 2
    wr(8'h04, 32'h02);
    wr(8'h00, ctl(1'b1, 1'b0, 2'h0, 3'h3, 8'h00));
    n = 0;
    // Interrupt enable is off here, so only the status word can tell
    while (n < 40)
    begin
      rd(8'h0C);
      n++;
      if (rdata[0] === 1'b1)
        break;
    end
    check("source three count", 32'h1, (n * 2 >= 4) && (n * 2 <= 12));
    wr(8'h0C, 32'h1);
    // Source 6 never ticks
    wr(8'h00, ctl(1'b1, 1'b0, 2'h0, 3'h6, 8'h00));
    repeat (20) @(posedge mclk);
    rd(8'h08); check("source six idle", 32'h0, rdata);
    stop_test();
  end
endmodule : compare_match_timer_bench

`default_nettype wire
